// ==== src/eew_consts.vh ====
// Purpose: Constants for the data EEPROM write controller
// Assumes: 25 MHz core clock, AXI4-Lite register access
// Notes: Offsets are byte addresses of 32-bit words
`ifndef EEW_CONSTS_VH
`define EEW_CONSTS_VH

// Register byte offsets
`define EEW_OFF_ADDR 8'h00
`define EEW_OFF_DATA 8'h04
`define EEW_OFF_CTRL 8'h08
`define EEW_OFF_KEY 8'h0c
`define EEW_OFF_FLAG 8'h10
`define EEW_OFF_IEN 8'h14
`define EEW_OFF_IPRI 8'h18
`define EEW_OFF_ICTL 8'h1c

// Control register bit positions
`define EEW_B_MEMSEL 7
`define EEW_B_CFGSEL 6
`define EEW_B_ROWERASE 4
`define EEW_B_ABORT 3
`define EEW_B_PERMIT 2
`define EEW_B_WR 1
`define EEW_B_RD 0

// Write-done bit in flag, enable and priority registers
`define EEW_B_DONE 4
// Implemented bits of flag, enable and priority registers
`define EEW_IRQ2_MASK 8'hd5

// Reset values
`define EEW_RST_ADDR 8'h00
`define EEW_RST_DATA 8'h00
`define EEW_RST_FLAG 8'h00
`define EEW_RST_IEN 8'h00
`define EEW_RST_IPRI 8'hd5
`define EEW_RST_ICTL 8'h00

// Unlock keys
`define EEW_KEY_FIRST 8'h55
`define EEW_KEY_SECOND 8'haa

// AXI responses
`define EEW_RESP_OKAY 2'b00
`define EEW_RESP_SLVERR 2'b10

// Timing
`define EEW_CLK_KHZ 25000
`define EEW_PWRT_MS 72
`define EEW_PWRT_CYC (`EEW_PWRT_MS * `EEW_CLK_KHZ)
`define EEW_WR_US 4000
`define EEW_WR_CYC ((`EEW_WR_US * `EEW_CLK_KHZ) / 1000)
`define EEW_CNT_W 21

`endif

// ==== src/eew_array.v ====
// Purpose: 256-byte data array held in flip-flops
// Assumes: One write port, two combinational read ports
// Notes: No reset, contents survive every reset like a nonvolatile cell
`timescale 1ns/1ps
module eew_array (
   clk,
   we,
   wAddr,
   wData,
   rAddrA,
   rAddrB,
   rDataA,
   rDataB
);
   input wire clk;
   input wire we;
   input wire [7:0] wAddr;
   input wire [7:0] wData;
   input wire [7:0] rAddrA;
   input wire [7:0] rAddrB;
   output wire [7:0] rDataA;
   output wire [7:0] rDataB;

   reg [7:0] mem_ff [0:255];

   always @(posedge clk) begin
      if (we) begin
         mem_ff[wAddr] <= wData;
      end
   end

   assign rDataA = mem_ff[rAddrA];
   assign rDataB = mem_ff[rAddrB];
endmodule // eew_array

// ==== src/eew_ctrl.v ====
// Purpose: Data EEPROM access controller with keyed self-timed write
// Assumes: rstn is power-on reset, warmRst a synchronous other reset
// Notes: External programming port is logic on the same clock
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "eew_consts.vh"

// Contract
// - Write starts only after 55h, AAh, then start
// - Start ignored while write permit is clear
// - Permit must be set by an earlier write
// - Hardware never clears write permit on completion
// - Control, address, data locked during write cycle
// - Completion clears start bit, sets done flag
// - Done flag sticky until software clears it
// - Write permit cleared at power-up
// - No array writes during 72 ms power-up timer
// - Code protect refuses external array reads, writes
// - Core reads and writes the array whatever the code protect setting
// - Space select set diverts access from array
// - Read start loads data next cycle, self-clears
// - Software can only set the start bit
// - Warm reset during write sets write abort flag
module eew_ctrl #(
   parameter [20:0] PWRT_CYCLES = `EEW_PWRT_CYC,
   parameter [20:0] WR_CYCLES = `EEW_WR_CYC
) (
   input wire clk,
   input wire rstn,
   input wire warmRst,
   input wire [1:0] codeProtect,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire extStb,
   input wire extWr,
   input wire [7:0] extAddr,
   input wire [7:0] extWdata,
   output wire [7:0] extRdata,
   output wire extAck,
   output wire extDenied
);
   localparam [1:0] KEY_IDLE = 2'd0;
   localparam [1:0] KEY_FIRST = 2'd1;
   localparam [1:0] KEY_ARMED = 2'd2;

   function isMapped;
      input [7:0] a;
      begin
         isMapped = (a[1:0] == 2'b00) && (a[7:5] == 3'b000);
      end
   endfunction

   // AXI bookkeeping
   reg awRdy_ff;
   reg wRdy_ff;
   reg [7:0] awAddr_ff;
   reg [7:0] wData_ff;
   reg wLane0_ff;
   reg bValid_ff;
   reg [1:0] bResp_ff;
   reg arRdy_ff;
   reg rValid_ff;
   reg [31:0] rData_ff;
   reg [1:0] rResp_ff;

   // Block state
   reg [7:0] addr_ff;
   reg [7:0] data_ff;
   reg memSel_ff;
   reg cfgSel_ff;
   reg rowErase_ff;
   reg abort_ff;
   reg permit_ff;
   reg wr_ff;
   reg rd_ff;
   reg [1:0] key_ff;
   reg [1:0] nxt_key;
   reg [20:0] wrCnt_ff;
   reg [20:0] pwrtCnt_ff;
   reg [7:0] flag_ff;
   reg [7:0] ien_ff;
   reg [7:0] ipri_ff;
   reg [7:0] ictl_ff;
   reg [7:0] extRdata_ff;
   reg extAck_ff;
   reg extDenied_ff;

   wire doWrite;
   wire regWr;
   wire [7:0] wd;
   wire pwrtRun;
   wire arrayTarget;
   wire wrStart;
   wire wrDone;
   wire extOk;
   wire extWe;
   wire [7:0] coreRd;
   wire [7:0] extRd;
   wire [7:0] ctrlView;

   assign doWrite = !awRdy_ff && !wRdy_ff && !bValid_ff;
   assign regWr = doWrite && wLane0_ff;
   assign wd = wData_ff;
   assign pwrtRun = (pwrtCnt_ff != 21'd0);
   assign arrayTarget = !memSel_ff && !cfgSel_ff;
   // Old permit value only, so one write setting both bits fails
   assign wrStart = regWr && (awAddr_ff == `EEW_OFF_CTRL) && wd[`EEW_B_WR]
      && permit_ff && (key_ff == KEY_ARMED) && !pwrtRun && !wr_ff;
   assign wrDone = wr_ff && (wrCnt_ff == 21'd0);
   assign extOk = (codeProtect == 2'b00)
      && !(extWr && (pwrtRun || wr_ff));
   assign extWe = extStb && extWr && extOk;
   assign ctrlView = {memSel_ff, cfgSel_ff, 1'b0, rowErase_ff,
      abort_ff, permit_ff, wr_ff, rd_ff};

   eew_array u_array (
      .clk(clk),
      .we((wrDone && arrayTarget && !warmRst) || extWe),
      .wAddr(wr_ff ? addr_ff : extAddr),
      .wData(wr_ff ? data_ff : extWdata),
      .rAddrA(addr_ff),
      .rAddrB(extAddr),
      .rDataA(coreRd),
      .rDataB(extRd)
   );

   // Unlock tracker
   always @* begin
      nxt_key = key_ff;
      if (regWr) begin
         if (awAddr_ff == `EEW_OFF_KEY) begin
            if (wd == `EEW_KEY_FIRST) begin
               nxt_key = KEY_FIRST;
            end else if (wd == `EEW_KEY_SECOND && key_ff == KEY_FIRST) begin
               nxt_key = KEY_ARMED;
            end else begin
               nxt_key = KEY_IDLE;
            end
         end else begin
            nxt_key = KEY_IDLE;
         end
      end
   end

   // AXI write channel
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         awRdy_ff <= 1'b1;
         wRdy_ff <= 1'b1;
         awAddr_ff <= 8'h00;
         wData_ff <= 8'h00;
         wLane0_ff <= 1'b0;
         bValid_ff <= 1'b0;
         bResp_ff <= 2'b00;
      end else begin
         if (s_axi_awvalid && awRdy_ff) begin
            awRdy_ff <= 1'b0;
            awAddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wRdy_ff) begin
            wRdy_ff <= 1'b0;
            wData_ff <= s_axi_wdata[7:0];
            wLane0_ff <= s_axi_wstrb[0];
         end
         if (doWrite) begin
            bValid_ff <= 1'b1;
            bResp_ff <= isMapped(awAddr_ff) ? `EEW_RESP_OKAY : `EEW_RESP_SLVERR;
         end
         if (bValid_ff && s_axi_bready) begin
            bValid_ff <= 1'b0;
            awRdy_ff <= 1'b1;
            wRdy_ff <= 1'b1;
         end
      end
   end

   // AXI read channel
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         arRdy_ff <= 1'b1;
         rValid_ff <= 1'b0;
         rData_ff <= 32'h00000000;
         rResp_ff <= 2'b00;
      end else begin
         if (s_axi_arvalid && arRdy_ff) begin
            arRdy_ff <= 1'b0;
            rValid_ff <= 1'b1;
            rResp_ff <= isMapped(s_axi_araddr) ? `EEW_RESP_OKAY : `EEW_RESP_SLVERR;
            case (s_axi_araddr)
               `EEW_OFF_ADDR: rData_ff <= {24'h000000, addr_ff};
               `EEW_OFF_DATA: rData_ff <= {24'h000000, data_ff};
               `EEW_OFF_CTRL: rData_ff <= {24'h000000, ctrlView};
               `EEW_OFF_FLAG: rData_ff <= {24'h000000, flag_ff};
               `EEW_OFF_IEN: rData_ff <= {24'h000000, ien_ff};
               `EEW_OFF_IPRI: rData_ff <= {24'h000000, ipri_ff};
               `EEW_OFF_ICTL: rData_ff <= {24'h000000, ictl_ff};
               // Key port is not a physical register and reads zero
               default: rData_ff <= 32'h00000000;
            endcase
         end
         if (rValid_ff && s_axi_rready) begin
            rValid_ff <= 1'b0;
            arRdy_ff <= 1'b1;
         end
      end
   end

   // Power-up timer, runs only after power-on reset
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pwrtCnt_ff <= PWRT_CYCLES;
      end else if (pwrtRun) begin
         pwrtCnt_ff <= pwrtCnt_ff - 21'd1;
      end
   end

   // Core register state
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         addr_ff <= `EEW_RST_ADDR;
         data_ff <= `EEW_RST_DATA;
         memSel_ff <= 1'b0;
         cfgSel_ff <= 1'b0;
         rowErase_ff <= 1'b0;
         abort_ff <= 1'b0;
         permit_ff <= 1'b0;
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
         key_ff <= KEY_IDLE;
         wrCnt_ff <= 21'd0;
         flag_ff <= `EEW_RST_FLAG;
         ien_ff <= `EEW_RST_IEN;
         ipri_ff <= `EEW_RST_IPRI;
         ictl_ff <= `EEW_RST_ICTL;
      end else if (warmRst) begin
         // Space selects survive so the failed access can be traced
         abort_ff <= abort_ff | wr_ff;
         addr_ff <= `EEW_RST_ADDR;
         data_ff <= `EEW_RST_DATA;
         rowErase_ff <= 1'b0;
         permit_ff <= 1'b0;
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
         key_ff <= KEY_IDLE;
         wrCnt_ff <= 21'd0;
         flag_ff <= `EEW_RST_FLAG;
         ien_ff <= `EEW_RST_IEN;
         ipri_ff <= `EEW_RST_IPRI;
         ictl_ff <= `EEW_RST_ICTL;
      end else begin
         key_ff <= nxt_key;
         if (rd_ff) begin
            rd_ff <= 1'b0;
            if (arrayTarget) begin
               data_ff <= coreRd;
            end
         end
         if (wr_ff) begin
            wrCnt_ff <= wrCnt_ff - 21'd1;
         end
         if (wrDone) begin
            wr_ff <= 1'b0;
         end
         if (wrStart) begin
            wr_ff <= 1'b1;
            wrCnt_ff <= WR_CYCLES - 21'd1;
         end
         if (regWr && !wr_ff) begin
            case (awAddr_ff)
               `EEW_OFF_ADDR: addr_ff <= wd;
               `EEW_OFF_DATA: data_ff <= wd;
               `EEW_OFF_CTRL: begin
                  memSel_ff <= wd[`EEW_B_MEMSEL];
                  cfgSel_ff <= wd[`EEW_B_CFGSEL];
                  rowErase_ff <= wd[`EEW_B_ROWERASE];
                  abort_ff <= wd[`EEW_B_ABORT];
                  permit_ff <= wd[`EEW_B_PERMIT];
                  // Read start is set-only and refused for program space
                  if (wd[`EEW_B_RD] && !wd[`EEW_B_MEMSEL] && !memSel_ff) begin
                     rd_ff <= 1'b1;
                  end
               end
               default: begin
               end
            endcase
         end
         if (regWr) begin
            case (awAddr_ff)
               `EEW_OFF_FLAG: flag_ff <= wd & `EEW_IRQ2_MASK;
               `EEW_OFF_IEN: ien_ff <= wd & `EEW_IRQ2_MASK;
               `EEW_OFF_IPRI: ipri_ff <= wd & `EEW_IRQ2_MASK;
               `EEW_OFF_ICTL: ictl_ff <= wd;
               default: begin
               end
            endcase
         end
         // Completion after the software write so a same-cycle clear loses
         if (wrDone) begin
            flag_ff[`EEW_B_DONE] <= 1'b1;
         end
      end
   end

   // External programming port
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         extRdata_ff <= 8'h00;
         extAck_ff <= 1'b0;
         extDenied_ff <= 1'b0;
      end else begin
         extAck_ff <= extStb && extOk;
         extDenied_ff <= extStb && !extOk;
         if (extStb && extOk && !extWr) begin
            extRdata_ff <= extRd;
         end
      end
   end

   assign s_axi_awready = awRdy_ff;
   assign s_axi_wready = wRdy_ff;
   assign s_axi_bvalid = bValid_ff;
   assign s_axi_bresp = bResp_ff;
   assign s_axi_arready = arRdy_ff;
   assign s_axi_rvalid = rValid_ff;
   assign s_axi_rdata = rData_ff;
   assign s_axi_rresp = rResp_ff;
   assign extRdata = extRdata_ff;
   assign extAck = extAck_ff;
   assign extDenied = extDenied_ff;
endmodule // eew_ctrl

// ==== tb/eew_ctrl_properties.sv ====
// Purpose: Port assertions for the data EEPROM write controller
// Assumes: Bound into every eew_ctrl instance
// Notes: Helper counter mirrors the power-up timer edge for edge from reset
`timescale 1ns/1ps
module eew_ctrl_props #(
   parameter [20:0] PWRT_CYCLES = 21'd40,
   parameter [20:0] WR_CYCLES = 21'd40
) (
   input wire clk,
   input wire rstn,
   input wire [1:0] codeProtect,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire extStb,
   input wire extWr,
   input wire extAck,
   input wire extDenied
);
   reg [20:0] upCnt_ff;
   reg [7:0] awAddr_ff;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         upCnt_ff <= 21'h0;
         awAddr_ff <= 8'h0;
      end else begin
         if (upCnt_ff < PWRT_CYCLES) upCnt_ff <= upCnt_ff + 21'h1;
         if (s_axi_awvalid && s_axi_awready) awAddr_ff <= s_axi_awaddr;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   ext_ack_cause_a: assert property (extAck |-> $past(extStb) && $past(codeProtect) == 2'h0)
      else $error("external ack without a permitted strobe");
   prot_deny_a: assert property (extStb && codeProtect != 2'h0 |=> extDenied && !extAck)
      else $error("protected external access not refused");
   pwrt_deny_a: assert property (extStb && extWr && upCnt_ff < PWRT_CYCLES |=> extDenied)
      else $error("array write accepted during power-up time");
   ext_deny_cause_a: assert property (extDenied |-> !extAck && $past(extStb))
      else $error("refusal without a strobe");
   resp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp ==
      ((awAddr_ff > 8'h1c || awAddr_ff[1:0] != 2'h0) ? 2'h2 : 2'h0))
      else $error("wrong write response code");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   chan_closed_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write channel open while answering");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
endmodule // eew_ctrl_props

bind eew_ctrl eew_ctrl_props #(.PWRT_CYCLES(PWRT_CYCLES), .WR_CYCLES(WR_CYCLES)) eew_ctrl_props_i (
   .clk(clk), .rstn(rstn), .codeProtect(codeProtect), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .extStb(extStb), .extWr(extWr), .extAck(extAck), .extDenied(extDenied));

// ==== tb/tb_eew_ctrl.sv ====
// Purpose: Self-checking bench for the data EEPROM write controller
// Assumes: Short power-up and write timers via parameters
// Notes: bready and rready stay high, always legal for a master
`timescale 1ns/1ps
module tb_eew_ctrl;
   reg clk, rstn, warmRst, awv, wv, arv, extStb, extWr;
   reg [1:0] cp, bRsp, rRsp, rsp;
   reg [7:0] awa, ara, exa, exd;
   reg [31:0] wd, rdv, row;
   reg [31:0] rows [0:8];
   wire awr, wr, bv, arr, rv, exAck, exDen;
   wire [1:0] br, rr;
   wire [31:0] rd;
   wire [7:0] exRd;
   integer errors, total_checks, cyc, i;
   eew_ctrl #(.PWRT_CYCLES(21'd40), .WR_CYCLES(21'd40)) eew_ctrl_i (.clk(clk), .rstn(rstn),
      .warmRst(warmRst), .codeProtect(cp), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
      .extStb(extStb), .extWr(extWr), .extAddr(exa), .extWdata(exd), .extRdata(exRd),
      .extAck(exAck), .extDenied(exDen));
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d errors %0d", total_checks, errors);
         if (errors == 0 && total_checks > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   // Hang guard: whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         errors = errors + 1;
         print_verdict;
      end
   end
   task axw(input [7:0] a, input [7:0] v);
      begin
         awa <= a;
         wd <= {24'h0, v};
         awv <= 1'b1;
         wv <= 1'b1;
         do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
         end while (!bv);
         bRsp = br;
      end
   endtask
   task axr(input [7:0] a);
      begin
         ara <= a;
         arv <= 1'b1;
         do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
         end while (!rv);
         rdv = rd;
         rRsp = rr;
      end
   endtask
   task seq(input [7:0] k1, input [7:0] k2, input [7:0] c);
      begin
         axw(8'h0c, k1);
         axw(8'h0c, k2);
         axw(8'h08, c);
         axr(8'h08);
      end
   endtask
   // Pulse outputs are read at the edge after the strobe is taken, while they stand
   task ext(input w, input [7:0] a, input [7:0] v);
      begin
         extStb <= 1'b1;
         extWr <= w;
         exa <= a;
         exd <= v;
         @(posedge clk);
         extStb <= 1'b0;
         @(posedge clk);
      end
   endtask
   initial begin
      {rstn, warmRst, awv, wv, arv, extStb, extWr, cp} = 0;
      {awa, ara, exa, exd, wd} = 0;
      errors = 0;
      total_checks = 0;
      cyc = 0;
      // Address, reset value, value written, value read back
      rows[0] = 32'h00_00_a5_a5;
      rows[1] = 32'h04_00_5a_5a;
      rows[2] = 32'h08_00_98_98;
      rows[3] = 32'h0c_00_ff_00;
      rows[4] = 32'h10_00_00_00;
      rows[5] = 32'h14_00_ff_d5;
      rows[6] = 32'h18_d5_2a_00;
      rows[7] = 32'h1c_00_3c_3c;
      rows[8] = 32'h20_00_11_00;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      for (i = 0; i < 9; i = i + 1) begin
         row = rows[i];
         rsp = (row[31:24] > 8'h1c) ? 2'h2 : 2'h0;
         axr(row[31:24]);
         chk(rdv, {24'h0, row[23:16]});
         chk(rRsp, rsp);
         axw(row[31:24], row[15:8]);
         chk(bRsp, rsp);
         axr(row[31:24]);
         chk(rdv, {24'h0, row[7:0]});
      end
      axw(8'h08, 8'h00);
      seq(8'h55, 8'haa, 8'h06);
      chk(rdv, 32'h04);
      axw(8'h08, 8'h00);
      seq(8'h55, 8'haa, 8'h02);
      chk(rdv, 32'h00);
      axw(8'h08, 8'h04);
      seq(8'haa, 8'h55, 8'h06);
      chk(rdv, 32'h04);
      seq(8'h55, 8'h55, 8'h06);
      chk(rdv, 32'h04);
      axw(8'h00, 8'h3c);
      axw(8'h0c, 8'h55);
      axw(8'h04, 8'ha7);
      axw(8'h0c, 8'haa);
      axw(8'h08, 8'h06);
      axr(8'h08);
      chk(rdv, 32'h04);
      cp <= 2'h3;
      seq(8'h55, 8'haa, 8'h06);
      chk(rdv, 32'h06);
      axw(8'h00, 8'h11);
      axr(8'h00);
      chk(rdv, 32'h3c);
      axw(8'h08, 8'h00);
      axr(8'h08);
      chk(rdv, 32'h06);
      axr(8'h10);
      chk(rdv, 32'h00);
      i = 0;
      do begin
         axr(8'h08);
         i = i + 1;
      end while (rdv[1] && i < 60);
      chk(rdv, 32'h04);
      axr(8'h10);
      chk(rdv, 32'h10);
      axw(8'h14, 8'h00);
      axr(8'h10);
      chk(rdv, 32'h10);
      axw(8'h10, 8'h00);
      axr(8'h10);
      chk(rdv, 32'h00);
      axw(8'h04, 8'h00);
      axw(8'h08, 8'h05);
      axr(8'h04);
      chk(rdv, 32'ha7);
      axr(8'h08);
      chk(rdv, 32'h04);
      ext(1'b0, 8'h3c, 8'h00);
      chk(exDen, 1'b1);
      cp <= 2'h0;
      ext(1'b0, 8'h3c, 8'h00);
      chk({exAck, exRd}, {1'b1, 8'ha7});
      axw(8'h04, 8'h00);
      axw(8'h08, 8'h81);
      axr(8'h04);
      chk(rdv, 32'h00);
      axw(8'h08, 8'h04);
      seq(8'h55, 8'haa, 8'h06);
      warmRst <= 1'b1;
      @(posedge clk);
      warmRst <= 1'b0;
      axr(8'h08);
      chk(rdv, 32'h08);
      axr(8'h00);
      chk(rdv, 32'h00);
      // Power-on reset restarts the timer; writes must be refused meanwhile
      rstn <= 1'b0;
      @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      ext(1'b1, 8'h3c, 8'hff);
      chk(exDen, 1'b1);
      axw(8'h08, 8'h04);
      seq(8'h55, 8'haa, 8'h06);
      chk(rdv, 32'h04);
      print_verdict;
   end
endmodule // tb_eew_ctrl
